// ### pkg/fpc_params.svh
`ifndef FPC_PARAMS_SVH
`define FPC_PARAMS_SVH

// command codes seen on the low data byte
`define FPC_CMD_READ_ARRAY 8'hff
`define FPC_CMD_READ_SIG 8'h90
`define FPC_CMD_READ_QUERY 8'h98
`define FPC_CMD_READ_STATUS 8'h70
`define FPC_CMD_CLR_STATUS 8'h50
`define FPC_CMD_SUSPEND 8'hb0
`define FPC_CMD_CONFIRM 8'hd0
`define FPC_CMD_ERASE 8'h20
`define FPC_CMD_BUFFER 8'he8
`define FPC_CMD_SETUP 8'h60
`define FPC_CMD_CFG_CONFIRM 8'h03
`define FPC_CMD_PROTECT 8'h01

// burst configuration field positions
`define FPC_CFG_LEN_LSB 0
`define FPC_CFG_LEN_MSB 2
`define FPC_CFG_WRAP_BIT 3
`define FPC_CFG_EDGE_BIT 6
`define FPC_CFG_YLAT_LSB 9
`define FPC_CFG_YLAT_MSB 10
`define FPC_CFG_XLAT_LSB 11
`define FPC_CFG_XLAT_MSB 14
`define FPC_CFG_ASYNC_BIT 15
`define FPC_CFG_RESET 16'h8000

// address fields of the bus
`define FPC_CFG_ADDR_LSB 2
`define FPC_CFG_ADDR_MSB 17
`define FPC_BLK_ADDR_LSB 17
`define FPC_BLK_ADDR_MSB 22
`define FPC_OFS_SIG_MANUF 16'h0000
`define FPC_OFS_SIG_DEVICE 16'h0001
`define FPC_OFS_SIG_PROT 16'h0002
`define FPC_NUM_BLOCKS 64
`define FPC_BUF_MAX_N 4'hf
`define FPC_WIDE_VARIANT 1'b1

// suspend latency limits
`define FPC_CLK_MHZ 100
`define FPC_PROG_SUSP_MAX_US 10
`define FPC_ERASE_SUSP_MAX_US 30
`define FPC_PROG_SUSP_CYC (`FPC_PROG_SUSP_MAX_US * `FPC_CLK_MHZ)
`define FPC_ERASE_SUSP_CYC (`FPC_ERASE_SUSP_MAX_US * `FPC_CLK_MHZ)

`endif

// ### pkg/fpc_pkg.sv
package fpc_pkg;

    // command interpreter states
    typedef enum logic [3:0] {
        ST_READ = 4'h0,
        ST_CFG_SETUP = 4'h1,
        ST_ERASE_SETUP = 4'h2,
        ST_BUF_COUNT = 4'h3,
        ST_BUF_LOAD = 4'h4,
        ST_BUF_CONFIRM = 4'h5,
        ST_BUSY = 4'h6,
        ST_PAUSING = 4'h7,
        ST_SUSPENDED = 4'h8
    } fpc_state_e;

    // what bus reads return
    typedef enum logic [1:0] {
        RM_ARRAY = 2'h0,
        RM_SIG = 2'h1,
        RM_QUERY = 2'h2,
        RM_STATUS = 2'h3
    } fpc_rmode_e;

    // operation handed to the program/erase controller
    typedef enum logic [1:0] {
        OP_ERASE = 2'h0,
        OP_PROGRAM = 2'h1,
        OP_PROTECT = 2'h2,
        OP_UNPROTECT = 2'h3
    } fpc_op_e;

endpackage : fpc_pkg

// ### verilog/fpc_cmd_if.sv
`timescale 1ns/1ps
`include "fpc_params.svh"

// Notes on behaviour
// RL1: burst configuration loads from 60h then 03h with value on address lines.
// RL2: after configuration update the device reads the array again.
// RL3: configuration value comes from A2..A17, bit 0 on A2; other lines ignored.
// RL4: configuration selects length, type, latencies, sync mode and clock edge.
// RL5: 60h then 01h latches block, starts controller, reads return status.
// RL6: 60h then D0h starts unprotect of all blocks, reads return status.
// RL7: during block protect only read status is accepted.
// RL8: during unprotect all only read status is accepted.
// RL9: protection flags survive reset; only unprotect all clears them.
// RL10: override level held throughout erase/program bypasses block protection.
// RL11: one-cycle commands FF, 90, 98, 70, 50, B0, D0 decode at any address.
// RL12: erase is 20h,D0h; buffer program is E8h, N, N+1 writes, D0h.
// RL13: signature gives maker at 0, device at 1, protection at block+2.
// RL14: signature address uses A22..A2 in x32 mode, A22..A1 in x16.
// RL15: upper data half exists only on the wide variant.
// RL16: program pauses within 10 us of suspend, erase within 30 us.
// RL17: host polls status until controller idle before another command.
module fpc_cmd_if #(
    parameter logic [15:0] MANUF_CODE = 16'h00a5, // arbitrary value
    parameter logic [15:0] DEVICE_CODE = 16'h005a // arbitrary value
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rstn_i,
    // bus write cycle
    input wire logic wr_stb_i,
    input wire logic [22:1] wr_addr_i,
    input wire logic [31:0] wr_data_i,
    // bus width and override pin
    input wire logic bus_x32_i,
    input wire logic override_high_level_i,
    // signature read
    input wire logic [22:1] rd_addr_i,
    output logic [31:0] sig_data_o,
    // read mode and burst configuration
    output fpc_pkg::fpc_rmode_e read_mode_o,
    output logic [15:0] burst_config_value_o,
    output logic [2:0] burst_len_o,
    output logic burst_wrap_o,
    output logic [3:0] x_lat_o,
    output logic [1:0] y_lat_o,
    output logic sync_mode_o,
    output logic clk_edge_o,
    // status side
    output logic clr_status_o,
    output logic seq_error_o,
    output logic prot_error_o,
    output logic pec_ready_o,
    output logic erase_susp_o,
    output logic prog_susp_o,
    // program/erase controller
    output logic pec_start_o,
    output fpc_pkg::fpc_op_e pec_op_o,
    output logic [5:0] pec_block_o,
    output logic pec_pause_o,
    output logic pec_resume_o,
    output logic pec_abort_o,
    output logic buf_wr_o,
    output logic [22:1] program_location_o,
    output logic [31:0] program_value_o,
    input wire logic pec_done_i,
    input wire logic pec_safe_i
);
    import fpc_pkg::*;

    fpc_state_e state_ff, nxt_state;
    fpc_rmode_e rmode_ff, nxt_rmode;
    fpc_op_e op_ff, nxt_op;
    logic [5:0] blk_ff, nxt_blk;
    logic [3:0] cnt_ff, nxt_cnt;
    logic ovr_used_ff, nxt_ovr_used;
    logic [15:0] cfg_ff;
    logic [63:0] prot_flags_ff;
    logic [11:0] susp_cnt_ff;
    logic [11:0] susp_limit;
    logic ovr_meta_ff, ovr_sync_ff;
    logic start_ff, clr_ff, seqerr_ff, proterr_ff, resume_ff, abort_ff, bufwr_ff;
    logic do_start, do_cfg, do_clr, do_seqerr, do_proterr, do_resume, do_abort, do_bufwr;
    logic [22:1] loc_ff;
    logic [31:0] val_ff, sig_ff;
    logic [7:0] cmd;
    logic [5:0] wr_blk, rd_blk;
    logic [15:0] rd_ofs;
    logic wide_x32, susp_done;

    assign cmd = wr_data_i[7:0];
    assign wr_blk = wr_addr_i[`FPC_BLK_ADDR_MSB:`FPC_BLK_ADDR_LSB];

    // override pin synchroniser
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            ovr_meta_ff <= 1'b0;
            ovr_sync_ff <= 1'b0;
        end else begin
            ovr_meta_ff <= override_high_level_i;
            ovr_sync_ff <= ovr_meta_ff;
        end
    end

    // suspend deadline by operation type
    assign susp_limit = (op_ff == OP_ERASE) ? 12'(`FPC_ERASE_SUSP_CYC) : 12'(`FPC_PROG_SUSP_CYC);
    assign susp_done = pec_safe_i || (susp_cnt_ff >= susp_limit - 12'h001); // RL16

    // command decoder
    always_comb begin
        nxt_state = state_ff;
        nxt_rmode = rmode_ff;
        nxt_op = op_ff;
        nxt_blk = blk_ff;
        nxt_cnt = cnt_ff;
        nxt_ovr_used = ovr_used_ff;
        do_start = 1'b0;
        do_cfg = 1'b0;
        do_clr = 1'b0;
        do_seqerr = 1'b0;
        do_proterr = 1'b0;
        do_resume = 1'b0;
        do_abort = 1'b0;
        do_bufwr = 1'b0;
        case (state_ff)
            ST_READ: begin
                if (wr_stb_i) begin
                    case (cmd) // RL11
                        `FPC_CMD_READ_ARRAY: nxt_rmode = RM_ARRAY;
                        `FPC_CMD_READ_SIG: nxt_rmode = RM_SIG;
                        `FPC_CMD_READ_QUERY: nxt_rmode = RM_QUERY;
                        `FPC_CMD_READ_STATUS: nxt_rmode = RM_STATUS;
                        `FPC_CMD_CLR_STATUS: do_clr = 1'b1;
                        `FPC_CMD_SETUP: nxt_state = ST_CFG_SETUP;
                        `FPC_CMD_ERASE: nxt_state = ST_ERASE_SETUP; // RL12
                        `FPC_CMD_BUFFER: begin // RL12
                            nxt_state = ST_BUF_COUNT;
                            nxt_blk = wr_blk;
                            nxt_rmode = RM_STATUS;
                        end
                        default: ;
                    endcase
                end
            end
            ST_CFG_SETUP: begin
                if (wr_stb_i) begin
                    nxt_rmode = RM_STATUS;
                    case (cmd)
                        `FPC_CMD_CFG_CONFIRM: begin // RL1
                            do_cfg = 1'b1;
                            nxt_rmode = RM_ARRAY; // RL2
                            nxt_state = ST_READ;
                        end
                        `FPC_CMD_PROTECT: begin // RL5
                            do_start = 1'b1;
                            nxt_op = OP_PROTECT;
                            nxt_blk = wr_blk;
                            nxt_ovr_used = 1'b0;
                            nxt_state = ST_BUSY;
                        end
                        `FPC_CMD_CONFIRM: begin // RL6
                            do_start = 1'b1;
                            nxt_op = OP_UNPROTECT;
                            nxt_ovr_used = 1'b0;
                            nxt_state = ST_BUSY;
                        end
                        default: begin
                            do_seqerr = 1'b1;
                            nxt_state = ST_READ;
                        end
                    endcase
                end
            end
            ST_ERASE_SETUP, ST_BUF_CONFIRM: begin
                if (wr_stb_i) begin
                    nxt_rmode = RM_STATUS;
                    nxt_state = ST_READ;
                    if (cmd != `FPC_CMD_CONFIRM) begin
                        do_seqerr = 1'b1;
                    end else begin
                        nxt_op = (state_ff == ST_ERASE_SETUP) ? OP_ERASE : OP_PROGRAM;
                        if (state_ff == ST_ERASE_SETUP) begin
                            nxt_blk = wr_blk;
                        end
                        if (prot_flags_ff[nxt_blk] && !ovr_sync_ff) begin
                            do_proterr = 1'b1; // RL10
                        end else begin
                            do_start = 1'b1;
                            nxt_ovr_used = prot_flags_ff[nxt_blk]; // RL10
                            nxt_state = ST_BUSY;
                        end
                    end
                end
            end
            ST_BUF_COUNT: begin
                if (wr_stb_i) begin
                    if (wr_data_i[31:4] != 28'h0) begin
                        do_seqerr = 1'b1;
                        nxt_state = ST_READ;
                    end else begin
                        nxt_cnt = wr_data_i[3:0];
                        nxt_state = ST_BUF_LOAD;
                    end
                end
            end
            ST_BUF_LOAD: begin
                if (wr_stb_i) begin
                    do_bufwr = 1'b1; // RL12
                    nxt_cnt = cnt_ff - 4'h1;
                    if (cnt_ff == 4'h0) begin
                        nxt_state = ST_BUF_CONFIRM;
                    end
                end
            end
            ST_BUSY: begin
                if (pec_done_i) begin
                    nxt_state = ST_READ;
                end else if (ovr_used_ff && !ovr_sync_ff) begin
                    do_abort = 1'b1; // RL10
                    nxt_state = ST_READ;
                end else if (wr_stb_i) begin
                    if (cmd == `FPC_CMD_READ_STATUS) begin // RL7 RL8
                        nxt_rmode = RM_STATUS;
                    end else if (cmd == `FPC_CMD_SUSPEND &&
                                 (op_ff == OP_ERASE || op_ff == OP_PROGRAM)) begin
                        nxt_rmode = RM_STATUS;
                        nxt_state = ST_PAUSING;
                    end
                end
            end
            ST_PAUSING: begin
                if (pec_done_i) begin
                    nxt_state = ST_READ;
                end else if (susp_done) begin
                    nxt_state = ST_SUSPENDED; // RL16
                end
                if (wr_stb_i && cmd == `FPC_CMD_READ_STATUS) begin
                    nxt_rmode = RM_STATUS;
                end
            end
            ST_SUSPENDED: begin
                if (wr_stb_i) begin
                    case (cmd)
                        `FPC_CMD_READ_ARRAY: nxt_rmode = RM_ARRAY;
                        `FPC_CMD_READ_SIG: nxt_rmode = RM_SIG;
                        `FPC_CMD_READ_QUERY: nxt_rmode = RM_QUERY;
                        `FPC_CMD_READ_STATUS: nxt_rmode = RM_STATUS;
                        `FPC_CMD_CONFIRM: begin
                            do_resume = 1'b1;
                            nxt_rmode = RM_STATUS;
                            nxt_state = ST_BUSY;
                        end
                        default: ;
                    endcase
                end
            end
            default: nxt_state = ST_READ;
        endcase
    end

    // state and operation registers
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            state_ff <= ST_READ;
            rmode_ff <= RM_ARRAY;
            op_ff <= OP_ERASE;
            blk_ff <= 6'h00;
            cnt_ff <= 4'h0;
            ovr_used_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            rmode_ff <= nxt_rmode;
            op_ff <= nxt_op;
            blk_ff <= nxt_blk;
            cnt_ff <= nxt_cnt;
            ovr_used_ff <= nxt_ovr_used;
        end
    end

    // one-cycle event outputs
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            start_ff <= 1'b0;
            clr_ff <= 1'b0;
            seqerr_ff <= 1'b0;
            proterr_ff <= 1'b0;
            resume_ff <= 1'b0;
            abort_ff <= 1'b0;
            bufwr_ff <= 1'b0;
            loc_ff <= 22'h0;
            val_ff <= 32'h0;
        end else begin
            start_ff <= do_start;
            clr_ff <= do_clr;
            seqerr_ff <= do_seqerr;
            proterr_ff <= do_proterr;
            resume_ff <= do_resume;
            abort_ff <= do_abort;
            bufwr_ff <= do_bufwr;
            if (do_bufwr) begin
                loc_ff <= wr_addr_i;
                val_ff <= wr_data_i;
            end
        end
    end

    // burst configuration register
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            cfg_ff <= `FPC_CFG_RESET;
        end else if (do_cfg) begin
            cfg_ff <= wr_addr_i[`FPC_CFG_ADDR_MSB:`FPC_CFG_ADDR_LSB]; // RL3
        end
    end

    // suspend latency counter
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i || state_ff != ST_PAUSING) begin
            susp_cnt_ff <= 12'h000;
        end else begin
            susp_cnt_ff <= susp_cnt_ff + 12'h001;
        end
    end

    // protection flags, deliberately kept through reset
    generate
        for (genvar b = 0; b < `FPC_NUM_BLOCKS; b++) begin : g_prot
            always_ff @(posedge core_clk_i) begin
                if (state_ff == ST_BUSY && pec_done_i) begin
                    if (op_ff == OP_UNPROTECT) begin
                        prot_flags_ff[b] <= 1'b0; // RL9
                    end else if (op_ff == OP_PROTECT && blk_ff == 6'(b)) begin
                        prot_flags_ff[b] <= 1'b1;
                    end
                end
            end
        end
    endgenerate

    // signature read map
    assign wide_x32 = bus_x32_i & `FPC_WIDE_VARIANT; // RL15
    assign rd_blk = rd_addr_i[`FPC_BLK_ADDR_MSB:`FPC_BLK_ADDR_LSB];
    assign rd_ofs = wide_x32 ? {1'b0, rd_addr_i[16:2]} : rd_addr_i[16:1]; // RL14
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            sig_ff <= 32'h0;
        end else if (rd_blk == 6'h00 && rd_ofs == `FPC_OFS_SIG_MANUF) begin
            sig_ff <= {16'h0, MANUF_CODE}; // RL13
        end else if (rd_blk == 6'h00 && rd_ofs == `FPC_OFS_SIG_DEVICE) begin
            sig_ff <= {16'h0, DEVICE_CODE};
        end else if (rd_ofs == `FPC_OFS_SIG_PROT) begin
            sig_ff <= {31'h0, prot_flags_ff[rd_blk]};
        end else begin
            sig_ff <= 32'h0;
        end
    end

    // outputs
    assign sig_data_o = sig_ff;
    assign read_mode_o = rmode_ff;
    assign burst_config_value_o = cfg_ff;
    assign burst_len_o = cfg_ff[`FPC_CFG_LEN_MSB:`FPC_CFG_LEN_LSB]; // RL4
    assign burst_wrap_o = cfg_ff[`FPC_CFG_WRAP_BIT];
    assign x_lat_o = cfg_ff[`FPC_CFG_XLAT_MSB:`FPC_CFG_XLAT_LSB];
    assign y_lat_o = cfg_ff[`FPC_CFG_YLAT_MSB:`FPC_CFG_YLAT_LSB];
    assign sync_mode_o = ~cfg_ff[`FPC_CFG_ASYNC_BIT];
    assign clk_edge_o = cfg_ff[`FPC_CFG_EDGE_BIT];
    assign clr_status_o = clr_ff;
    assign seq_error_o = seqerr_ff;
    assign prot_error_o = proterr_ff;
    assign pec_ready_o = (state_ff != ST_BUSY) && (state_ff != ST_PAUSING);
    assign erase_susp_o = (state_ff == ST_SUSPENDED) && (op_ff == OP_ERASE);
    assign prog_susp_o = (state_ff == ST_SUSPENDED) && (op_ff == OP_PROGRAM);
    assign pec_start_o = start_ff;
    assign pec_op_o = op_ff;
    assign pec_block_o = blk_ff;
    assign pec_pause_o = (state_ff == ST_PAUSING) || (state_ff == ST_SUSPENDED);
    assign pec_resume_o = resume_ff;
    assign pec_abort_o = abort_ff;
    assign buf_wr_o = bufwr_ff;
    assign program_location_o = loc_ff;
    assign program_value_o = val_ff;

    // checks
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);

    property p_cfg_load;
        state_ff == ST_CFG_SETUP && wr_stb_i && cmd == `FPC_CMD_CFG_CONFIRM
            |=> burst_config_value_o == $past(wr_addr_i[17:2]) && !pec_start_o;
    endproperty
    a_cfg_load: assert property (p_cfg_load) else $error("config not loaded"); // RL1

    property p_cfg_array;
        state_ff == ST_CFG_SETUP && wr_stb_i && cmd == `FPC_CMD_CFG_CONFIRM
            |=> read_mode_o == RM_ARRAY && pec_ready_o;
    endproperty
    a_cfg_array: assert property (p_cfg_array) else $error("no array mode"); // RL2

    property p_protect_start;
        state_ff == ST_CFG_SETUP && wr_stb_i && cmd == `FPC_CMD_PROTECT
            |=> pec_start_o && pec_op_o == OP_PROTECT && read_mode_o == RM_STATUS
                && pec_block_o == $past(wr_addr_i[22:17]);
    endproperty
    a_protect_start: assert property (p_protect_start) else $error("bad protect"); // RL5

    property p_unprotect_start;
        state_ff == ST_CFG_SETUP && wr_stb_i && cmd == `FPC_CMD_CONFIRM
            |=> pec_start_o && pec_op_o == OP_UNPROTECT && !pec_ready_o ##1 !pec_start_o;
    endproperty
    a_unprotect_start: assert property (p_unprotect_start) else $error("bad unprotect"); // RL6

    property p_protect_lock;
        state_ff == ST_BUSY && op_ff inside {OP_PROTECT, OP_UNPROTECT} && wr_stb_i
            && cmd != `FPC_CMD_READ_STATUS && !pec_done_i
            |=> state_ff == ST_BUSY && $stable(read_mode_o);
    endproperty
    a_protect_lock: assert property (p_protect_lock) else $error("cmd accepted"); // RL7

    property p_flags_hold;
        !(state_ff == ST_BUSY && op_ff == OP_UNPROTECT && pec_done_i) && (|prot_flags_ff)
            |=> (~prot_flags_ff & $past(prot_flags_ff)) == 64'h0;
    endproperty
    a_flags_hold: assert property (p_flags_hold) else $error("flag lost"); // RL9

    property p_prot_block;
        state_ff == ST_ERASE_SETUP && wr_stb_i && cmd == `FPC_CMD_CONFIRM
            && prot_flags_ff[wr_blk] && !ovr_sync_ff
            |=> prot_error_o && !pec_start_o && pec_ready_o;
    endproperty
    a_prot_block: assert property (p_prot_block) else $error("erase not blocked"); // RL10

    property p_sig_mode;
        state_ff == ST_READ && wr_stb_i && cmd == `FPC_CMD_READ_SIG
            |=> read_mode_o == RM_SIG [*1] ##1 1'b1;
    endproperty
    a_sig_mode: assert property (p_sig_mode) else $error("no sig mode"); // RL11

    property p_sig_manuf;
        rd_addr_i == 22'h0 |=> sig_data_o == {16'h0, MANUF_CODE};
    endproperty
    a_sig_manuf: assert property (p_sig_manuf) else $error("bad maker code"); // RL13

    property p_prog_pause;
        $rose(state_ff == ST_PAUSING) && op_ff == OP_PROGRAM
            |-> ##[1:1000] state_ff != ST_PAUSING;
    endproperty
    a_prog_pause: assert property (p_prog_pause) else $error("pause too late"); // RL16

endmodule : fpc_cmd_if

// ### testbench/fpc_pec_model.sv
`timescale 1ns/1ps

// controller stand-in: finishes dly_i+1 cycles after a start, pauses on request
module fpc_pec_model (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rstn_i,
    // requests from the interpreter
    input wire logic start_i,
    input wire logic pause_i,
    input wire logic resume_i,
    input wire logic abort_i,
    input wire logic [7:0] dly_i,
    // answers to the interpreter
    output logic done_o,
    output logic safe_o
);
    logic run_ff;
    logic [7:0] cnt_ff;

    // run, count down, report done; a pause freezes the count
    always_ff @(posedge core_clk_i) begin
        done_o <= 1'b0;
        safe_o <= pause_i && run_ff;
        if (!rstn_i) begin
            run_ff <= 1'b0;
            cnt_ff <= 8'h00;
            safe_o <= 1'b0;
        end else if (abort_i) begin
            run_ff <= 1'b0;
        end else if (start_i || resume_i) begin
            run_ff <= 1'b1;
            cnt_ff <= dly_i;
        end else if (run_ff && !pause_i) begin
            if (cnt_ff == 8'h00) begin
                run_ff <= 1'b0;
                done_o <= 1'b1;
            end else begin
                cnt_ff <= cnt_ff - 8'h01;
            end
        end
    end
endmodule : fpc_pec_model

// ### testbench/tb_flash_protect_config_commands.sv
`timescale 1ns/1ps
`include "fpc_params.svh"

module tb_flash_protect_config_commands;
    import fpc_pkg::*;
    logic core_clk_i, rstn_i, wr_stb_i, bus_x32_i, override_high_level_i, pec_done_i, pec_safe_i;
    logic [22:1] wr_addr_i, rd_addr_i, program_location_o;
    logic [31:0] wr_data_i, sig_data_o, program_value_o;
    fpc_rmode_e read_mode_o;
    fpc_op_e pec_op_o;
    logic [15:0] burst_config_value_o;
    logic [2:0] burst_len_o;
    logic [3:0] x_lat_o;
    logic [1:0] y_lat_o;
    logic [5:0] pec_block_o;
    logic [7:0] dly;
    logic burst_wrap_o, sync_mode_o, clk_edge_o, clr_status_o, seq_error_o, prot_error_o;
    logic pec_ready_o, erase_susp_o, prog_susp_o, pec_start_o, pec_pause_o, pec_resume_o;
    logic pec_abort_o, buf_wr_o;
    int mismatches = 0;
    int checks_done = 0;
    logic [15:0] cfg = 16'h4e2b;

    fpc_cmd_if fpc_cmd_if_i (.core_clk_i, .rstn_i, .wr_stb_i, .wr_addr_i, .wr_data_i,
        .bus_x32_i, .override_high_level_i, .rd_addr_i, .sig_data_o, .read_mode_o,
        .burst_config_value_o, .burst_len_o, .burst_wrap_o, .x_lat_o, .y_lat_o, .sync_mode_o,
        .clk_edge_o, .clr_status_o, .seq_error_o, .prot_error_o, .pec_ready_o, .erase_susp_o,
        .prog_susp_o, .pec_start_o, .pec_op_o, .pec_block_o, .pec_pause_o, .pec_resume_o,
        .pec_abort_o, .buf_wr_o, .program_location_o, .program_value_o, .pec_done_i,
        .pec_safe_i);

    fpc_pec_model fpc_pec_model_i (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
        .start_i(pec_start_o), .pause_i(pec_pause_o), .resume_i(pec_resume_o),
        .abort_i(pec_abort_o), .dly_i(dly), .done_o(pec_done_i), .safe_o(pec_safe_i));

    // 100 MHz clock
    initial begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end

    task print_verdict;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : print_verdict

    task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", n, exp, seen);
        end
    endtask : chk

    // one bus write, strobe left high for back-to-back writes
    task wr(input logic [7:0] c, input logic [22:1] a);
        wr_stb_i = 1'b1;
        wr_data_i = {24'h0, c};
        wr_addr_i = a;
        @(negedge core_clk_i);
    endtask : wr

    task idle(input int n);
        wr_stb_i = 1'b0;
        repeat (n) @(negedge core_clk_i);
    endtask : idle

    // bounded poll of the controller idle flag
    task wait_ready;
        for (int i = 0; i < 300; i++) begin
            if (pec_ready_o === 1'b1) return;
            @(negedge core_clk_i);
        end
        mismatches++;
        $display("mismatch wait_ready expected 1 seen %h", pec_ready_o);
        print_verdict();
    endtask : wait_ready

    task sig(input logic [5:0] b, input logic [15:0] o, input logic x32, input logic [31:0] e);
        bus_x32_i = x32;
        rd_addr_i = x32 ? {b, o[14:0], 1'b0} : {b, o};
        @(negedge core_clk_i);
        chk("sig_data", sig_data_o, e);
    endtask : sig

    task prot_op(input logic [7:0] c, input logic [5:0] b, input fpc_op_e op, input logic [7:0] bad);
        dly = 8'd12;
        wr(`FPC_CMD_SETUP, {b, 16'h0});
        wr(c, {b, 16'h0077});
        chk("start", pec_start_o, 1'b1);
        chk("op", pec_op_o, op);
        chk("mode", read_mode_o, RM_STATUS);
        wr(bad, 22'h0);
        idle(2);
        chk("ignored", read_mode_o, RM_STATUS);
        chk("busy", pec_ready_o, 1'b0);
        wait_ready();
    endtask : prot_op

    initial begin
        {rstn_i, wr_stb_i, bus_x32_i, override_high_level_i} = 4'h0;
        wr_addr_i = 22'h0;
        rd_addr_i = 22'h0;
        wr_data_i = 32'h0;
        dly = 8'd0;
        repeat (2) @(negedge core_clk_i);
        rstn_i = 1'b1;
        chk("cfg_reset", burst_config_value_o, `FPC_CFG_RESET);
        chk("ready", pec_ready_o, 1'b1);
        // configuration on A17..A2, other lines set to show they are ignored
        wr(`FPC_CMD_SETUP, {5'h1f, cfg, 1'b1});
        wr(`FPC_CMD_CFG_CONFIRM, {5'h15, cfg, 1'b1});
        idle(1);
        chk("cfg", burst_config_value_o, cfg);
        chk("cfg_mode", read_mode_o, RM_ARRAY);
        chk("len", burst_len_o, cfg[`FPC_CFG_LEN_MSB:`FPC_CFG_LEN_LSB]);
        chk("wrap", burst_wrap_o, cfg[`FPC_CFG_WRAP_BIT]);
        chk("edge", clk_edge_o, cfg[`FPC_CFG_EDGE_BIT]);
        chk("ylat", y_lat_o, cfg[`FPC_CFG_YLAT_MSB:`FPC_CFG_YLAT_LSB]);
        chk("xlat", x_lat_o, cfg[`FPC_CFG_XLAT_MSB:`FPC_CFG_XLAT_LSB]);
        chk("sync", sync_mode_o, !cfg[`FPC_CFG_ASYNC_BIT]);
        prot_op(`FPC_CMD_CONFIRM, 6'd9, OP_UNPROTECT, `FPC_CMD_READ_SIG);
        prot_op(`FPC_CMD_PROTECT, 6'd5, OP_PROTECT, `FPC_CMD_READ_ARRAY);
        // single-cycle read and clear-status commands, any address
        wr(`FPC_CMD_READ_ARRAY, 22'h2aaaaa);
        chk("m_ff", read_mode_o, RM_ARRAY);
        wr(`FPC_CMD_READ_QUERY, 22'h155555);
        chk("m_98", read_mode_o, RM_QUERY);
        wr(`FPC_CMD_READ_STATUS, 22'h0f0f0f);
        chk("m_70", read_mode_o, RM_STATUS);
        wr(`FPC_CMD_CLR_STATUS, 22'h3fffff);
        chk("clr", clr_status_o, 1'b1);
        wr(`FPC_CMD_READ_SIG, 22'h123456);
        idle(1);
        chk("m_90", read_mode_o, RM_SIG);
        sig(6'd0, `FPC_OFS_SIG_MANUF, 1'b0, 32'h00a5);
        sig(6'd0, `FPC_OFS_SIG_DEVICE, 1'b0, 32'h005a);
        sig(6'd5, `FPC_OFS_SIG_PROT, 1'b0, 32'h1);
        sig(6'd9, `FPC_OFS_SIG_PROT, 1'b0, 32'h0);
        sig(6'd5, `FPC_OFS_SIG_PROT, 1'b1, 32'h1);
        sig(6'd0, `FPC_OFS_SIG_DEVICE, 1'b1, 32'h005a);
        // flags survive a reset in mid-run
        rstn_i = 1'b0;
        idle(2);
        rstn_i = 1'b1;
        chk("rst_mode", read_mode_o, RM_ARRAY);
        wr(`FPC_CMD_READ_SIG, 22'h0);
        idle(1);
        sig(6'd5, `FPC_OFS_SIG_PROT, 1'b0, 32'h1);
        // erase of a protected block refused without override
        wr(`FPC_CMD_ERASE, {6'd5, 16'h0});
        wr(`FPC_CMD_CONFIRM, {6'd5, 16'h0});
        chk("prot_err", prot_error_o, 1'b1);
        chk("no_start", pec_start_o, 1'b0);
        idle(1);
        override_high_level_i = 1'b1;
        dly = 8'd40;
        idle(3);
        wr(`FPC_CMD_ERASE, {6'd5, 16'h0});
        wr(`FPC_CMD_CONFIRM, {6'd5, 16'h0});
        chk("erase", pec_start_o, 1'b1);
        chk("erase_op", pec_op_o, OP_ERASE);
        wr(`FPC_CMD_SUSPEND, 22'h0);
        chk("pause", pec_pause_o, 1'b1);
        idle(3);
        chk("susp", erase_susp_o, 1'b1);
        wr(`FPC_CMD_CONFIRM, 22'h0);
        chk("resume", pec_resume_o, 1'b1);
        idle(1);
        wait_ready();
        wr(`FPC_CMD_BUFFER, {6'd9, 16'h0});
        wr(8'h01, 22'h0);
        wr(8'h5c, 22'h6);
        chk("pv", program_value_o, 8'h5c);
        chk("pl", program_location_o, 22'h6);
        wr(8'h3e, 22'h7);
        wr(`FPC_CMD_CONFIRM, 22'h0);
        wr(`FPC_CMD_SUSPEND, 22'h0);
        idle(3);
        chk("psusp", prog_susp_o, 1'b1);
        wr(`FPC_CMD_CONFIRM, 22'h0);
        idle(1);
        wait_ready();
        wr(`FPC_CMD_ERASE, 22'h0);
        wr(`FPC_CMD_READ_ARRAY, 22'h0);
        chk("seq", seq_error_o, 1'b1);
        override_high_level_i = 1'b0;
        idle(2);
        print_verdict();
    end
endmodule : tb_flash_protect_config_commands
